//--- logic/abu_top.v
// Address breakpoint unit: registers, break sequencing and outputs.
// Assumes the CPU core and system integration logic share sys_clk_i.
// Register bytes travel in lane 0 of each 32-bit bus word.
//
// Notes on behaviour
// - Enabled full 16-bit address equality requests break
// - Match enable bit 7, read/write, reset clear
// - Hardware sets active flag on address match
// - Software writing 1 to active flag breaks
// - Writing 0 or reset clears active flag
// - Two byte registers form compare address
// - Reset clears both break address bytes
// - Watchdog held off in break when set
// - Flag shows wait mode ended by break
// - Wait exit flag kept only in emulation
// - In break, status clears need enable bit
// - Unit stays enabled through wait and stop
// - No address match in wait or stop; a pending operand break still goes out
// - Match asserts breakpoint request to integration unit
// - Opcode match stops instruction before execution
// - Operand match lets instruction finish first
// - Software break taken before next instruction
`timescale 1ns/1ps

`include "abu_defs.vh"

module abu_top #(
  parameter AW = 16
) (
  // Clock, reset, enable
  input  wire          sys_clk_i,
  input  wire          nrst_i,
  input  wire          clk_en_i,
  // Avalon-MM slave
  input  wire [4:0]    avs_address_i,
  input  wire          avs_read_i,
  input  wire          avs_write_i,
  input  wire [31:0]   avs_writedata_i,
  input  wire [3:0]    avs_byteenable_i,
  output wire [31:0]   avs_readdata_o,
  output wire          avs_waitrequest_o,
  // CPU core
  input  wire [AW-1:0] cpu_addr_i,
  input  wire          cpu_addr_valid_i,
  input  wire          cpu_opcode_fetch_i,
  input  wire          cpu_instr_start_i,
  input  wire          cpu_rti_i,
  // System state
  input  wire          wait_mode_i,
  input  wire          stop_mode_i,
  input  wire          emul_mode_i,
  // System integration
  output wire          breakpoint_request_o,
  output wire          in_break_o,
  output wire          watchdog_timer_hold_o,
  output wire          status_clear_allow_o
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg        en_q;
  reg        en_d;
  reg        act_q;
  reg        act_d;
  reg [7:0]  adh_q;
  reg [7:0]  adh_d;
  reg [7:0]  adl_q;
  reg [7:0]  adl_d;
  reg        wdoff_q;
  reg        wdoff_d;
  reg        wexit_q;
  reg        wexit_d;
  reg        clren_q;
  reg        clren_d;
  reg        swpend_q;
  reg        swpend_d;
  reg        argpend_q;
  reg        argpend_d;
  reg        inbrk_q;
  reg        inbrk_d;
  reg [7:0]  rmux;

  wire       wr_fire;
  wire       hit_op;
  wire       hit_arg;
  wire       brk_req;
  wire       clr_ok;
  wire [7:0] wbyte = avs_writedata_i[7:0];

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  // Registers are one byte wide, so only lane 0 carries a write.
  // A write with lane 0 disabled is dropped as a whole.
  function wsel;
    input [4:0] a;
    input [4:0] o;
    input       fire;
    input       be0;
    begin
      wsel = fire & be0 & (a == o);
    end
  endfunction

  wire wr_scr = wsel(avs_address_i, `ABU_OFS_SCR, wr_fire, avs_byteenable_i[0]);
  wire wr_adh = wsel(avs_address_i, `ABU_OFS_ADH, wr_fire, avs_byteenable_i[0]);
  wire wr_adl = wsel(avs_address_i, `ABU_OFS_ADL, wr_fire, avs_byteenable_i[0]);
  wire wr_aux = wsel(avs_address_i, `ABU_OFS_AUX, wr_fire, avs_byteenable_i[0]);
  wire wr_wst = wsel(avs_address_i, `ABU_OFS_WST, wr_fire, avs_byteenable_i[0]);
  wire wr_fcr = wsel(avs_address_i, `ABU_OFS_FCR, wr_fire, avs_byteenable_i[0]);

  wire sw_brk = wr_scr & wbyte[`ABU_SCR_ACT];
  wire sw_clr = wr_scr & ~wbyte[`ABU_SCR_ACT];

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  abu_avs u_avs (
    .sys_clk_i     (sys_clk_i),
    .nrst_i        (nrst_i),
    .clk_en_i      (clk_en_i),
    .read_i        (avs_read_i),
    .write_i       (avs_write_i),
    .rdata_i       (rmux),
    .waitrequest_o (avs_waitrequest_o),
    .readdata_o    (avs_readdata_o),
    .wr_fire_o     (wr_fire)
  );

  // ----------------------------------------
  // Address compare
  // ----------------------------------------
  // Enable is not touched by low power; only the hits are masked.
  abu_cmp #(
    .AW (AW)
  ) u_cmp (
    .addr_i         (cpu_addr_i),
    .addr_valid_i   (cpu_addr_valid_i),
    .opcode_fetch_i (cpu_opcode_fetch_i),
    .low_power_i    (wait_mode_i | stop_mode_i),
    .break_addr_i   ({adh_q, adl_q}),
    .enable_i       (en_q),
    .hit_op_o       (hit_op),
    .hit_arg_o      (hit_arg)
  );

  // ----------------------------------------
  // Break request
  // ----------------------------------------
  // Opcode hits go out at once so the fetched opcode is replaced;
  // operand and software breaks wait for the next instruction.
  // Pending breaks are not masked in low power, so a software break
  // can still end wait mode.
  assign brk_req = clk_en_i & (hit_op |
                   ((swpend_q | argpend_q) & cpu_instr_start_i));

  // ----------------------------------------
  // Outputs to the integration unit
  // ----------------------------------------
  // The watchdog hold is not limited to monitor sessions, so a break
  // taken in any mode keeps the watchdog quiet while it lasts, provided wdoff_q is set.
  assign breakpoint_request_o  = brk_req;
  assign in_break_o            = inbrk_q;
  assign watchdog_timer_hold_o = inbrk_q & wdoff_q;
  assign clr_ok                = ~inbrk_q | clren_q;
  assign status_clear_allow_o  = clr_ok;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always @* begin
    en_d      = en_q;
    act_d     = act_q;
    adh_d     = adh_q;
    adl_d     = adl_q;
    wdoff_d   = wdoff_q;
    wexit_d   = wexit_q;
    clren_d   = clren_q;
    swpend_d  = swpend_q;
    argpend_d = argpend_q;
    inbrk_d   = inbrk_q;

    // Register writes land on the edge that ends the bus answer cycle
    if (wr_scr) begin
      en_d = wbyte[`ABU_SCR_EN];
    end
    if (wr_adh) begin
      adh_d = wbyte;
    end
    if (wr_adl) begin
      adl_d = wbyte;
    end
    if (wr_aux) begin
      wdoff_d = wbyte[`ABU_AUX_WDOFF];
    end
    if (wr_fcr) begin
      clren_d = wbyte[`ABU_FCR_CLREN];
    end

    // A held equal address sets the flag again on every valid cycle,
    // so the routine must move the break address before clearing it.
    // Set wins over a clear in the same cycle
    if (hit_op | hit_arg | sw_brk) begin
      act_d = 1'b1;
    end else if (sw_clr) begin
      act_d = 1'b0;
    end

    // A request consumes both pending breaks; a new cause in the same
    // cycle is kept for the next instruction start.
    if (brk_req) begin
      swpend_d  = 1'b0;
      argpend_d = 1'b0;
    end
    if (sw_brk) begin
      swpend_d = 1'b1;
    end
    if (hit_arg) begin
      argpend_d = 1'b1;
    end

    // A request inside the routine is not masked: break state stays
    // set, and only a return with no new request leaves it.
    if (brk_req) begin
      inbrk_d = 1'b1;
    end else if (cpu_rti_i) begin
      inbrk_d = 1'b0;
    end

    // Clears of the wait-exit flag obey the break clear permission,
    // while the routine may always clear the break-active flag.
    // Outside emulation the flag simply holds its value
    if (emul_mode_i) begin
      if (brk_req & wait_mode_i) begin
        wexit_d = 1'b1;
      end else if (wr_wst & ~wbyte[`ABU_WST_EXIT] & clr_ok) begin
        wexit_d = 1'b0;
      end
    end
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  // A low clock enable freezes every register, bus handshake included.
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      en_q      <= `ABU_RST_BIT;
      act_q     <= `ABU_RST_BIT;
      adh_q     <= `ABU_RST_BYTE;
      adl_q     <= `ABU_RST_BYTE;
      wdoff_q   <= `ABU_RST_BIT;
      wexit_q   <= `ABU_RST_BIT;
      clren_q   <= `ABU_RST_BIT;
      swpend_q  <= `ABU_RST_BIT;
      argpend_q <= `ABU_RST_BIT;
      inbrk_q   <= `ABU_RST_BIT;
    end else if (clk_en_i) begin
      en_q      <= en_d;
      act_q     <= act_d;
      adh_q     <= adh_d;
      adl_q     <= adl_d;
      wdoff_q   <= wdoff_d;
      wexit_q   <= wexit_d;
      clren_q   <= clren_d;
      swpend_q  <= swpend_d;
      argpend_q <= argpend_d;
      inbrk_q   <= inbrk_d;
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // Unused bits and unmapped offsets read as zero.
  always @* begin
    rmux = `ABU_RST_BYTE;
    case (avs_address_i)
      `ABU_OFS_SCR: begin
        rmux[`ABU_SCR_EN]  = en_q;
        rmux[`ABU_SCR_ACT] = act_q;
      end
      `ABU_OFS_ADH: begin
        rmux = adh_q;
      end
      `ABU_OFS_ADL: begin
        rmux = adl_q;
      end
      `ABU_OFS_AUX: begin
        rmux[`ABU_AUX_WDOFF] = wdoff_q;
      end
      `ABU_OFS_WST: begin
        rmux[`ABU_WST_EXIT] = wexit_q;
      end
      `ABU_OFS_FCR: begin
        rmux[`ABU_FCR_CLREN] = clren_q;
      end
      default: begin
        rmux = `ABU_RST_BYTE;
      end
    endcase
  end

endmodule // abu_top

//--- logic/abu_defs.vh
// Constants for the address breakpoint unit.
// Assumes an Avalon-MM byte address of ABU_AW bits, one 32-bit word each.
`ifndef ABU_DEFS_VH
`define ABU_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ABU_AW        5
`define ABU_OFS_SCR   5'h00
`define ABU_OFS_ADH   5'h04
`define ABU_OFS_ADL   5'h08
`define ABU_OFS_AUX   5'h0c
`define ABU_OFS_WST   5'h10
`define ABU_OFS_FCR   5'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ABU_SCR_EN    7
`define ABU_SCR_ACT   6
`define ABU_AUX_WDOFF 0
`define ABU_WST_EXIT  1
`define ABU_FCR_CLREN 7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ABU_RST_BYTE  8'h00
`define ABU_RST_BIT   1'b0
`define ABU_ZERO_HI   24'h000000

`endif

//--- logic/abu_avs.v
// Avalon-MM slave handshake for the breakpoint unit.
// Assumes a master that holds its request until waitrequest is low.
`timescale 1ns/1ps

`include "abu_defs.vh"

module abu_avs (
  // Clock and reset
  input  wire        sys_clk_i,
  input  wire        nrst_i,
  input  wire        clk_en_i,
  // Bus request
  input  wire        read_i,
  input  wire        write_i,
  input  wire [7:0]  rdata_i,
  // Bus answer
  output wire        waitrequest_o,
  output wire [31:0] readdata_o,
  output wire        wr_fire_o
);

  reg        ack_q;
  reg [31:0] rdat_q;
  wire       req = read_i | write_i;
  wire       done = ack_q & clk_en_i;

  // ----------------------------------------
  // One wait state on every access
  // ----------------------------------------
  // Read data are sampled in the wait cycle, so an event in the
  // answer cycle shows on the next read only.
  assign waitrequest_o = req & ~done;
  assign wr_fire_o     = write_i & done;
  assign readdata_o    = rdat_q;

  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_q  <= `ABU_RST_BIT;
      rdat_q <= {`ABU_ZERO_HI, `ABU_RST_BYTE};
    end else if (clk_en_i) begin
      ack_q <= req & ~ack_q;
      if (read_i & ~ack_q) begin
        rdat_q <= {`ABU_ZERO_HI, rdata_i};
      end
    end
  end

endmodule // abu_avs

//--- logic/abu_cmp.v
// Address comparator of the breakpoint unit.
// Assumes the CPU marks valid program addresses and opcode fetches.
`timescale 1ns/1ps

module abu_cmp #(
  parameter AW = 16
) (
  // CPU address
  input  wire [AW-1:0] addr_i,
  input  wire          addr_valid_i,
  input  wire          opcode_fetch_i,
  input  wire          low_power_i,
  // Settings
  input  wire [AW-1:0] break_addr_i,
  input  wire          enable_i,
  // Hits
  output wire          hit_op_o,
  output wire          hit_arg_o
);

  // The bus stands still in low power, so a stale equal value
  // there must not fire.
  wire hit = enable_i & addr_valid_i & ~low_power_i &
             (addr_i == break_addr_i);

  assign hit_op_o  = hit & opcode_fetch_i;
  assign hit_arg_o = hit & ~opcode_fetch_i;

endmodule // abu_cmp

//--- tb/abu_cpu_model.sv
// CPU core model: loops 0x0100-0x011f, two bytes per instruction.
// Assumes the bench clock; returns from every break 4 cycles later.
`timescale 1ns/1ps

module abu_cpu_model (
  // Clock, reset, break request
  input  wire         sys_clk_i,
  input  wire         nrst_i,
  input  wire         brk_i,
  // CPU side
  output logic [15:0] addr_o,
  output wire         fetch_o,
  output wire         rti_o
);
  logic [2:0] rti_cnt_q;

  // Opcode at even, operand at odd; an opcode fetch starts an instruction
  assign fetch_o = !addr_o[0];
  assign rti_o   = (rti_cnt_q == 3'h1);

  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      addr_o    <= 16'h0100;
      rti_cnt_q <= 3'h0;
    end else begin
      addr_o <= {11'h008, addr_o[4:0] + 5'h01};
      if (brk_i)
        rti_cnt_q <= 3'h4;
      else if (rti_cnt_q != 3'h0)
        rti_cnt_q <= rti_cnt_q - 3'h1;
    end
  end
endmodule // abu_cpu_model

//--- tb/abu_top_asserts.sv
// Port assertions for abu_top, attached by bind.
// Assumes clk_en_i held high by the bench.
`timescale 1ns/1ps

module abu_top_asserts (
  // Clock and reset
  input wire        sys_clk_i,
  input wire        nrst_i,
  // Watched ports
  input wire        avs_read_i,
  input wire        avs_write_i,
  input wire [31:0] avs_readdata_o,
  input wire        avs_waitrequest_o,
  input wire        cpu_instr_start_i,
  input wire        cpu_rti_i,
  input wire        wait_mode_i,
  input wire        stop_mode_i,
  input wire        breakpoint_request_o,
  input wire        in_break_o,
  input wire        watchdog_timer_hold_o,
  input wire        status_clear_allow_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);

  a_req_sets_break: assert property (breakpoint_request_o |=> in_break_o)
    else $error("no break state after request");
  a_rti_ends_break: assert property (cpu_rti_i && !breakpoint_request_o |=> !in_break_o)
    else $error("break state kept after return");
  // Pending breaks may still leave at an instruction start in low power
  a_lowpwr_no_break: assert property ((wait_mode_i || stop_mode_i) && !cpu_instr_start_i
    |-> !breakpoint_request_o)
    else $error("break in low power");
  a_wdog_only_break: assert property (!in_break_o |-> !watchdog_timer_hold_o)
    else $error("watchdog held outside break");
  a_clear_free_run: assert property (!in_break_o |-> status_clear_allow_o)
    else $error("clears blocked outside break");
  a_read_hi_zero: assert property (avs_read_i && !avs_waitrequest_o
    |-> avs_readdata_o[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_wait_first: assert property ($rose(avs_read_i) || $rose(avs_write_i) |-> avs_waitrequest_o)
    else $error("no wait state");
  a_wait_bound: assert property (avs_read_i || avs_write_i |-> ##[0:1] !avs_waitrequest_o)
    else $error("access not answered");
  a_reset_idle: assert property ($rose(nrst_i) |-> !in_break_o && !breakpoint_request_o)
    else $error("break active after reset");

  c_wait_break: cover property (breakpoint_request_o && wait_mode_i);
  c_wdog_hold:  cover property (watchdog_timer_hold_o);
  c_return:     cover property (in_break_o && cpu_rti_i);
endmodule // abu_top_asserts

bind abu_top abu_top_asserts abu_top_asserts_inst (
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .cpu_instr_start_i(cpu_instr_start_i), .cpu_rti_i(cpu_rti_i), .wait_mode_i(wait_mode_i),
  .stop_mode_i(stop_mode_i), .breakpoint_request_o(breakpoint_request_o),
  .in_break_o(in_break_o), .watchdog_timer_hold_o(watchdog_timer_hold_o),
  .status_clear_allow_o(status_clear_allow_o));

//--- tb/tb_top.sv
// Bench: registers, address and software breaks, low power, wait exit.
// Assumes abu_cpu_model drives the CPU side; clk_en_i tied high.
`timescale 1ns/1ps
`include "abu_defs.vh"

module tb_top;
  logic        sys_clk_i = 1'b0, nrst_i = 1'b0, rd_i = 1'b0, wr_i = 1'b0, be_i = 1'b1;
  logic        wait_i = 1'b0, stop_i = 1'b0, emul_i = 1'b0;
  logic [4:0]  adr_i = 5'h00;
  logic [7:0]  wd_i = 8'h00;
  logic [31:0] q, v;
  wire  [31:0] rdata;
  wire  [15:0] caddr;
  wire         wreq, req, inbrk, hold, clr, fetch, rti;
  int          n_fail = 0, n_checks = 0, n_req = 0, seed = 32'h540e311e, i, c0;
  logic [4:0]  ofs [4] = '{`ABU_OFS_ADH, `ABU_OFS_ADL, `ABU_OFS_AUX, `ABU_OFS_FCR};
  logic [7:0]  msk [4] = '{8'hff, 8'hff, 8'h01, 8'h80};

  always #20 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    if (req === 1'b1)
      n_req <= n_req + 1;
  end

  abu_top abu_top_inst (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .clk_en_i(1'b1),
    .avs_address_i(adr_i), .avs_read_i(rd_i), .avs_write_i(wr_i),
    .avs_writedata_i({24'h0, wd_i}), .avs_byteenable_i({3'h0, be_i}), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .cpu_addr_i(caddr), .cpu_addr_valid_i(1'b1),
    .cpu_opcode_fetch_i(fetch), .cpu_instr_start_i(fetch), .cpu_rti_i(rti),
    .wait_mode_i(wait_i), .stop_mode_i(stop_i), .emul_mode_i(emul_i),
    .breakpoint_request_o(req), .in_break_o(inbrk), .watchdog_timer_hold_o(hold),
    .status_clear_allow_o(clr));
  abu_cpu_model abu_cpu_model_inst (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .brk_i(req),
    .addr_o(caddr), .fetch_o(fetch), .rti_o(rti));

  // ----
  // Tasks
  // ----
  task print_verdict();
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", s, e, g);
    end
  endtask

  // Holds the request until waitrequest is sampled low
  task bus(input logic w, input logic [4:0] a, input logic [7:0] d, input logic be);
    int k;
    k = 0;
    adr_i <= a;
    wd_i <= d;
    be_i <= be;
    rd_i <= !w;
    wr_i <= w;
    @(posedge sys_clk_i);
    while (wreq !== 1'b0) begin
      k++;
      if (k > 20) begin
        n_fail++;
        print_verdict();
      end
      @(posedge sys_clk_i);
    end
    q = rdata;
    rd_i <= 1'b0;
    wr_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  task rdc(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 1'b1);
    chk("register", {24'h0, e}, q & {24'h0, m});
  endtask

  task waitb(input logic lv);
    for (int k = 0; inbrk !== lv; k++) begin
      if (k > 40) begin
        n_fail++;
        print_verdict();
      end
      @(posedge sys_clk_i);
    end
  endtask

  task run(input int e);
    c0 = n_req;
    repeat (64) @(posedge sys_clk_i);
    chk("break count", e, n_req - c0);
  endtask

  // ----
  // Scenarios
  // ----
  initial begin
    repeat (2) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    for (i = 0; i < 7; i++) rdc(5'(i * 4), 8'hff, 8'h00);
    for (i = 0; i < 16; i++) begin
      v = $random(seed);
      bus(1'b1, ofs[i % 4], v[7:0], 1'b1);
      rdc(ofs[i % 4], msk[i % 4], v[7:0] & msk[i % 4]);
    end
    bus(1'b1, `ABU_OFS_ADH, 8'h01, 1'b1);
    bus(1'b1, `ABU_OFS_ADH, 8'hfe, 1'b0);
    rdc(`ABU_OFS_ADH, 8'hff, 8'h01);
    bus(1'b1, 5'h18, 8'hff, 1'b1);
    rdc(5'h18, 8'hff, 8'h00);
    $display("done registers");
    bus(1'b1, `ABU_OFS_ADL, 8'h08, 1'b1);
    bus(1'b1, `ABU_OFS_FCR, 8'h00, 1'b1);
    bus(1'b1, `ABU_OFS_AUX, 8'h01, 1'b1);
    bus(1'b1, `ABU_OFS_SCR, 8'h00, 1'b1);
    run(0);
    rdc(`ABU_OFS_SCR, 8'hc0, 8'h00);
    bus(1'b1, `ABU_OFS_SCR, 8'h80, 1'b1);
    run(2);
    rdc(`ABU_OFS_SCR, 8'hc0, 8'hc0);
    for (i = 0; i < 2; i++) begin
      wait_i <= (i == 0);
      stop_i <= (i == 1);
      run(0);
    end
    stop_i <= 1'b0;
    run(2);
    bus(1'b1, `ABU_OFS_ADL, 8'h09, 1'b1);
    run(2);
    $display("done address breaks");
    bus(1'b1, `ABU_OFS_SCR, 8'h00, 1'b1);
    // An operand break still pending at the disable must run out first
    repeat (8) @(posedge sys_clk_i);
    waitb(1'b0);
    c0 = n_req;
    bus(1'b1, `ABU_OFS_SCR, 8'h40, 1'b1);
    waitb(1'b1);
    chk("watchdog hold", 32'h1, {31'h0, hold});
    chk("clear allow", 32'h0, {31'h0, clr});
    waitb(1'b0);
    chk("break count", 32'h1, n_req - c0);
    rdc(`ABU_OFS_SCR, 8'hc0, 8'h40);
    bus(1'b1, `ABU_OFS_SCR, 8'h00, 1'b1);
    rdc(`ABU_OFS_SCR, 8'hc0, 8'h00);
    $display("done software break");
    emul_i <= 1'b1;
    wait_i <= 1'b1;
    bus(1'b1, `ABU_OFS_SCR, 8'h40, 1'b1);
    waitb(1'b1);
    wait_i <= 1'b0;
    // Still in break with clears disabled, so the flag must survive
    bus(1'b1, `ABU_OFS_WST, 8'h00, 1'b1);
    rdc(`ABU_OFS_WST, 8'h02, 8'h02);
    waitb(1'b0);
    bus(1'b1, `ABU_OFS_WST, 8'h00, 1'b1);
    rdc(`ABU_OFS_WST, 8'h02, 8'h00);
    $display("done wait exit");
    print_verdict();
  end
endmodule // tb_top
